// file: bodc_brownout_control.sv
`include "bodc_consts.svh"
`default_nettype none
module bodc_brownout_control
    import bodc_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // initial power-on indication from the power-on detector, one clock pulse
    input wire logic power_on_event_in,
    // analogue comparator, high while supply is below the trip level
    input wire logic trip_below_in,
    // configuration fuse and interrupt enable
    input wire logic brownout_fuse_enable_in,
    input wire logic brownout_irq_enable_in,
    // power control register write
    input wire logic power_control_reg_wr_in,
    input wire logic [7:0] power_control_reg_data_in,
    // reset source register write; a zero bit clears that flag
    input wire logic reset_source_reg_wr_in,
    input wire logic [7:0] reset_source_reg_data_in,
    // status and responses
    output logic [7:0] power_control_reg_out,
    output logic brownout_flag_out,
    output logic power_on_flag_out,
    output logic brownout_active_out,
    output logic brownout_reset_out,
    output logic brownout_irq_out
);
    bodc_ctrl_s ctrl;
    bodc_flags_s flags;
    logic trip_sync;
    logic active;
    logic bo_event;
    logic irq_mode;
    logic fuse_sync;

    function automatic logic detect_active(input logic fuse, input bodc_ctrl_s c);
        detect_active = fuse && !c.detector_powerdown_bit
            && (c.power_reduction_field != `BODC_PMOD_TOTAL_PD);
    endfunction

    bodc_sync u_trip_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .async_in(trip_below_in),
        .level_out(trip_sync)
    );

    // fuse is static but comes from outside, so it is synchronised as well
    bodc_sync u_fuse_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .async_in(brownout_fuse_enable_in),
        .level_out(fuse_sync)
    );

    assign active = detect_active(fuse_sync, ctrl);
    assign bo_event = active && trip_sync;
    assign irq_mode = ctrl.brownout_irq_select && brownout_irq_enable_in;

    // power control bits; power-down bit comes up clear
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl.detector_powerdown_bit <= `BODC_DETECTOR_POWERDOWN_BIT_RESET;
            ctrl.brownout_irq_select <= 1'h0;
            ctrl.power_reduction_field <= 2'h0;
        end else if (power_control_reg_wr_in) begin
            ctrl.detector_powerdown_bit <= power_control_reg_data_in[`BODC_POWER_CONTROL_REG_DETECTOR_POWERDOWN_BIT_BIT];
            ctrl.brownout_irq_select <= power_control_reg_data_in[`BODC_POWER_CONTROL_REG_BOI_BIT];
            ctrl.power_reduction_field <=
                power_control_reg_data_in[`BODC_POWER_CONTROL_REG_PMOD_HI:`BODC_POWER_CONTROL_REG_PMOD_LO];
        end
    end

    // other control bits of the power control byte are held for readback only
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            power_control_reg_out <= `BODC_POWER_CONTROL_REG_RESET;
        end else if (power_control_reg_wr_in) begin
            power_control_reg_out <= power_control_reg_data_in;
        end
    end

    // sticky flags; a hardware set wins over a software clear in the same cycle
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            flags <= {`BODC_FLAG_RESET, `BODC_FLAG_RESET};
        end else begin
            if (bo_event || (power_on_event_in && fuse_sync)) begin
                flags.brownout_flag <= 1'h1;
            end else if (reset_source_reg_wr_in && !reset_source_reg_data_in[`BODC_RSRC_BOF_BIT]) begin
                flags.brownout_flag <= 1'h0;
            end
            if (power_on_event_in) begin
                flags.power_on_flag <= 1'h1;
            end else if (reset_source_reg_wr_in && !reset_source_reg_data_in[`BODC_RSRC_POF_BIT]) begin
                flags.power_on_flag <= 1'h0;
            end
        end
    end

    assign brownout_flag_out = flags.brownout_flag;
    assign power_on_flag_out = flags.power_on_flag;

    // responses registered; reset follows the live condition, irq follows the flag
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            brownout_active_out <= 1'h0;
            brownout_reset_out <= 1'h0;
            brownout_irq_out <= 1'h0;
        end else begin
            brownout_active_out <= active;
            brownout_reset_out <= bo_event && !irq_mode;
            brownout_irq_out <= active && irq_mode && (flags.brownout_flag || bo_event);
        end
    end
endmodule
`default_nettype wire

// file: bodc_consts.svh
`ifndef BODC_CONSTS_SVH
`define BODC_CONSTS_SVH
// power reduction field value that shuts the detector circuitry off
`define BODC_PMOD_TOTAL_PD 2'h3
// bit positions within the reset source byte
`define BODC_RSRC_BOF_BIT 5
`define BODC_RSRC_POF_BIT 4
// bit positions within the power control byte
`define BODC_POWER_CONTROL_REG_DETECTOR_POWERDOWN_BIT_BIT 5
`define BODC_POWER_CONTROL_REG_BOI_BIT 4
`define BODC_POWER_CONTROL_REG_PMOD_HI 1
`define BODC_POWER_CONTROL_REG_PMOD_LO 0
// reset values
`define BODC_DETECTOR_POWERDOWN_BIT_RESET 1'h0
`define BODC_FLAG_RESET 1'h0
`define BODC_POWER_CONTROL_REG_RESET 8'h00
`endif

// file: bodc_pkg.sv
`default_nettype none
package bodc_pkg;
    // power control bits that steer the detector
    typedef struct packed {
        logic detector_powerdown_bit;
        logic brownout_irq_select;
        logic [1:0] power_reduction_field;
    } bodc_ctrl_s;
    // sticky flags of the reset source register
    typedef struct packed {
        logic brownout_flag;
        logic power_on_flag;
    } bodc_flags_s;
endpackage
`default_nettype wire

// file: bodc_sync.sv
`default_nettype none
module bodc_sync (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic async_in,
    output logic level_out
);
    logic [2:0] stage;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            stage <= 3'h0;
        end else begin
            stage <= {stage[1:0], async_in};
        end
    end
    // a change counts only once the second and third stages agree
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            level_out <= 1'h0;
        end else if (stage[1] == stage[2]) begin
            level_out <= stage[2];
        end
    end
endmodule
`default_nettype wire

// file: bodc_partner.sv
`default_nettype none
module bodc_partner (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [1:0] req_in,
    output logic seen_out
);
    // the core a reset or interrupt would redirect is not modelled, only that a request arrived
    always_ff @(posedge mclk_in or posedge rst_in) seen_out <= rst_in ? 1'h0 : seen_out | (|req_in);
endmodule
`default_nettype wire

// file: bodc_monitor.sv
`default_nettype none
module bodc_monitor (
    input wire logic mclk_in, rst_in, power_on_event_in, trip_below_in, brownout_fuse_enable_in,
    input wire logic brownout_irq_enable_in, reset_source_reg_wr_in, brownout_flag_out, power_on_flag_out,
    input wire logic brownout_active_out, brownout_reset_out, brownout_irq_out,
    input wire logic [7:0] reset_source_reg_data_in, power_control_reg_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // six edges let a pin settle through the synchroniser
    sequence fuse_s; brownout_fuse_enable_in [*6]; endsequence
    wire logic clr = reset_source_reg_wr_in && !reset_source_reg_data_in[5];
    wire logic off = power_control_reg_out[5] || &power_control_reg_out[1:0];
    fuse_off_a: assert property (!brownout_fuse_enable_in [*6] |=> !brownout_active_out) else $error("active");
    pd_off_a: assert property (off |=> !brownout_active_out) else $error("active when off");
    det_on_a: assert property (fuse_s ##0 !off |=> brownout_active_out) else $error("inactive");
    rst_req_a: assert property (trip_below_in [*6] ##0 brownout_active_out && !power_control_reg_out[4]
        |=> brownout_reset_out || !brownout_active_out) else $error("no reset");
    irq_why_a: assert property (brownout_irq_out |-> $past(brownout_irq_enable_in) && !brownout_reset_out)
        else $error("stray irq");
    flag_hold_a: assert property (brownout_flag_out && !clr |=> brownout_flag_out) else $error("flag lost");
    flag_clr_a: assert property (clr && !power_on_event_in |=> !brownout_flag_out || brownout_active_out)
        else $error("flag kept");
    pof_set_a: assert property (fuse_s ##0 power_on_event_in |=> power_on_flag_out && brownout_flag_out)
        else $error("flags");
endmodule
`default_nettype wire

// file: tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 1'h0, rst_in = 1'h1, power_on_event_in = 1'h0, trip_below_in = 1'h0, brownout_irq_enable_in = 1'h0;
    logic brownout_fuse_enable_in = 1'h0, power_control_reg_wr_in = 1'h0, reset_source_reg_wr_in = 1'h0, seen;
    logic [7:0] power_control_reg_data_in = 8'h00, reset_source_reg_data_in = 8'h00, power_control_reg_out;
    logic brownout_flag_out, power_on_flag_out, brownout_active_out, brownout_reset_out, brownout_irq_out;
    wire logic [4:0] st = {brownout_flag_out, power_on_flag_out, brownout_active_out, brownout_reset_out,
        brownout_irq_out};
    int err_total = 0, comparisons = 0;
    bodc_brownout_control u_dut (.*);
    bodc_partner u_far (.mclk_in, .rst_in, .req_in({brownout_reset_out, brownout_irq_out}), .seen_out(seen));
    initial forever #20 mclk_in = ~mclk_in;
    task automatic cyc(input int n); repeat (n) @(negedge mclk_in); endtask
    // eight cycles outlast the pin synchroniser
    task automatic trip(input logic v); trip_below_in = v; cyc(8); endtask
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        comparisons++;
        if (got !== exp) err_total++;
        if (got !== exp) $display("wrong value at %0t: %h not %h", $time, got, exp);
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) err_total++;
        if (got !== exp) $display("wrong value at %0t: byte %h not %h", $time, got, exp);
    endtask
    // strobes stay low a full cycle so back-to-back writes never retoggle them in one time step
    task automatic wr(input logic pc, input logic [7:0] d);
        {power_control_reg_data_in, reset_source_reg_data_in} = {d, d};
        {power_control_reg_wr_in, reset_source_reg_wr_in} = {pc, !pc};
        cyc(1);
        {power_control_reg_wr_in, reset_source_reg_wr_in} = 2'h0;
        cyc(1);
    endtask
    task automatic sc_power_up;
        trip(1'h1);
        chk(st, 5'h00);
        trip(1'h0);
        brownout_fuse_enable_in = 1'h1;
        cyc(8);
        chk(st, 5'h04);
        power_on_event_in = 1'h1;
        cyc(1);
        power_on_event_in = 1'h0;
        chk(st, 5'h1c);
        wr(1'h0, 8'hcf);
        chk(st, 5'h04);
    endtask
    task automatic sc_trip;
        trip(1'h1);
        chk(st, 5'h16);
        trip(1'h0);
        chk({st[4:1], seen}, 5'h15);
        wr(1'h0, 8'hdf);
        brownout_irq_enable_in = 1'h1;
        wr(1'h1, 8'h10);
        chk_byte(power_control_reg_out, 8'h10);
        trip(1'h1);
        chk(st, 5'h15);
        trip(1'h0);
        chk(st, 5'h15);
        wr(1'h0, 8'hdf);
        cyc(1);
        chk(st, 5'h04);
    endtask
    task automatic sc_modes;
        for (int i = 0; i < 8; i++) begin
            wr(1'h1, {2'h0, i[2], 3'h0, i[1:0]});
            cyc(1);
            chk(st, {2'h0, !i[2] && i[1:0] != 2'h3, 2'h0});
            chk_byte(power_control_reg_out, {2'h0, i[2], 3'h0, i[1:0]});
        end
    endtask
    // last mode pass leaves the detector powered down, so a fresh reset must bring it back
    task automatic sc_reset;
        rst_in = 1'h1;
        cyc(2);
        rst_in = 1'h0;
        chk(st, 5'h00);
        cyc(8);
        chk(st, 5'h04);
        chk_byte(power_control_reg_out, 8'h00);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        cyc(10);
        rst_in = 1'h0;
        sc_power_up;
        sc_trip;
        sc_modes;
        sc_reset;
        give_verdict;
    end
endmodule
bind bodc_brownout_control bodc_monitor u_mon (.*);
`default_nettype wire
